// File: charger_regs_pkg.sv
// Package of register offsets, field positions, reset values and codes for the charger bank
package charger_regs_pkg;

	// Register offsets
	localparam logic [7:0] ADDR_CURRENT = 8'h03;
	localparam logic [7:0] ADDR_LOOP = 8'h04;
	localparam logic [7:0] ADDR_TIMER = 8'h05;

	// Reset values (unknown bits taken as zero)
	localparam logic [7:0] RST_CURRENT = 8'hf8;
	localparam logic [7:0] RST_LOOP = 8'h02;
	localparam logic [7:0] RST_TIMER = 8'ha8;

	// Field positions
	localparam int CHG_LSB = 3;
	localparam int TERM_LSB = 0;
	localparam int LOOP_LSB = 6;
	localparam int REDUCED_BIT = 5;
	localparam int FORCE_DET_BIT = 4;
	localparam int INHIBIT_BIT = 3;
	localparam int FLOOR_LSB = 0;
	localparam int STRETCH_BIT = 7;
	localparam int LIMIT_LSB = 5;
	localparam int ISOLATE_BIT = 4;
	localparam int THERM_EN_BIT = 3;
	localparam int THERM_LSB = 0;

	// Base values and steps, millivolts and milliamps
	localparam logic [15:0] VBAT_BASE_MV = 16'h0dac;
	localparam logic [15:0] VBAT_STEP_MV = 16'h0014;
	localparam logic [15:0] CHG_BASE_MA = 16'h01f4;
	localparam logic [15:0] CHG_STEP_MA = 16'h0032;
	localparam logic [15:0] TERM_BASE_MA = 16'h0032;
	localparam logic [15:0] TERM_STEP_MA = 16'h0019;
	localparam logic [15:0] REDUCED_MA = 16'h014a;
	localparam logic [15:0] FLOOR_BASE_MV = 16'h1068;
	localparam logic [15:0] FLOOR_STEP_MV = 16'h0050;
	localparam logic [15:0] RESTRICT_MV = 16'h0f3c;
	localparam logic [15:0] RESTRICT_MA = 16'h0064;
	localparam logic [4:0] CHG_EXTERNAL = 5'h1f;
	localparam logic [3:0] TERM_DIVISOR = 4'ha;

	// Loop status codes
	typedef enum logic [1:0] {
		LOOP_NONE = 2'b00,
		LOOP_FLOOR = 2'b01,
		LOOP_INLIM = 2'b10,
		LOOP_THERMAL = 2'b11
	} loop_code_e;

	// Safety limit codes and limits in minutes
	localparam logic [1:0] LIMIT_SHORT = 2'b00;
	localparam logic [1:0] LIMIT_SIX = 2'b01;
	localparam logic [1:0] LIMIT_NINE = 2'b10;
	localparam logic [1:0] LIMIT_OFF = 2'b11;
	localparam logic [9:0] MIN_SHORT = 10'h02d;
	localparam logic [9:0] MIN_SIX = 10'h168;
	localparam logic [9:0] MIN_NINE = 10'h21c;

	// Thermistor fault codes
	localparam logic [2:0] THERM_NORMAL = 3'b000;
	localparam logic [2:0] THERM_COLD = 3'b100;
	localparam logic [2:0] THERM_ZONE = 3'b101;
	localparam logic [2:0] THERM_FREEZE = 3'b110;
	localparam logic [2:0] THERM_OPEN = 3'b111;

endpackage : charger_regs_pkg

// File: loop_arbiter.sv
// Picks one regulation loop to own charging, first come keeps it
`timescale 1ns/1ps
module loop_arbiter (
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire logic floor_req_i,
	input wire logic inlim_req_i,
	input wire logic thermal_req_i,
	output logic [1:0] owner_o
);
	typedef struct packed {
		logic [1:0] owner;
	} arb_s;

	arb_s st_q;
	arb_s st_d;

	// Owner holds while its request stands; a free slot goes to highest priority
	always_comb begin
		logic own_live;
		own_live = 1'b0;
		st_d = st_q;
		unique case (st_q.owner)
			2'b01: own_live = floor_req_i;
			2'b10: own_live = inlim_req_i;
			2'b11: own_live = thermal_req_i;
			2'b00: own_live = 1'b0;
		endcase
		if (!own_live) begin
			if (thermal_req_i) begin
				st_d.owner = 2'b11;
			end else if (inlim_req_i) begin
				st_d.owner = 2'b10;
			end else if (floor_req_i) begin
				st_d.owner = 2'b01;
			end else begin
				st_d.owner = 2'b00;
			end
		end
	end

	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign owner_o = st_q.owner;

	a_owner_stable: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		(st_q.owner == 2'b01 && floor_req_i) |=> (st_q.owner == 2'b01))
		else $error("Loop owner changed while still requesting");
endmodule : loop_arbiter

// File: charger_config_registers.sv
// Charger control and status register bank with its decoded settings
// Behaviour
// - Battery voltage is 3.5 V plus 20 mV per code step
// - Two-bit port field holds port detection or the config pin levels; no register offset reads it back
// - Charge current is 500 mA plus 800/400/200/100/50 mA bit weights
// - All five charge bits one selects external resistor current
// - Termination is 50 mA plus 100/50/25 mA weights, default zero
// - External mode terminates at one tenth of charge current; the termination output reads zero then
// - Loop status: 00 none, 01 floor, 10 input limit, 11 thermal
// - Loop status latches on engagement and holds until host reads it
// - Only the first engaged loop is reported
// - Only one regulation loop controls charging at a time
// - Reduced-current bit forces 330 mA charge current
// - Force-detection bit starts one detection run, clears when done
// - Read-only bit shows charge-inhibit pin level
// - Input floor is 4.20 V plus 320/160/80 mV weights, default 4.36 V
// - Stretch bit halves timer speed in thermal, floor or system loop
// - Limit code: 0.75 h, 6 h, 9 h, or timers disabled
// - Thermistor monitor runs only while enabled, enable resets to one
// - Thermistor status 000 normal, 100 cold, 110 freeze, 111 open or off
// - Three-zone variant reports 101 between freeze and cold, restricted
// - Isolate bit with input gone switches battery FET off
`timescale 1ns/1ps
module charger_config_registers #(
	parameter bit THREE_ZONE = 1'b0,
	parameter bit DETECT_VARIANT = 1'b1
) (
	input wire logic clk_sys_i,
	input wire logic rst_i,
	// Host register port, single-cycle strobes
	input wire logic wr_en_i,
	input wire logic rd_en_i,
	input wire logic [7:0] addr_i,
	input wire logic [7:0] wdata_i,
	output logic [7:0] rdata_o,
	// Battery regulation code from the neighbouring register
	input wire logic [5:0] battery_regulation_voltage_i,
	// Pins and analog status, asynchronous
	input wire logic [1:0] config_pins_i,
	input wire logic charge_inhibit_pin_i,
	input wire logic input_present_i,
	input wire logic floor_loop_i,
	input wire logic inlim_loop_i,
	input wire logic thermal_loop_i,
	input wire logic system_power_loop_i,
	input wire logic temp_cold_i,
	input wire logic temp_freeze_i,
	input wire logic sensor_open_i,
	// Detection engine handshake, same clock
	input wire logic detect_done_i,
	input wire logic [1:0] detect_result_i,
	// Decoded settings
	output logic [15:0] battery_voltage_mv_o,
	output logic [15:0] charge_current_ma_o,
	output logic external_current_program_o,
	output logic [15:0] termination_ma_o,
	output logic [15:0] input_floor_mv_o,
	output logic detect_start_o,
	output logic timer_half_speed_o,
	output logic [9:0] safety_limit_min_o,
	output logic safety_timer_off_o,
	output logic thermistor_active_o,
	output logic charge_suspend_o,
	output logic battery_fet_off_o,
	output logic [1:0] loop_owner_o
);
	localparam int SYNC_W = 11;

	typedef struct packed {
		logic [SYNC_W-1:0] sync1;
		logic [SYNC_W-1:0] sync2;
		logic [4:0] charge_current_code;
		logic [2:0] termination_threshold;
		logic [1:0] loop_code;
		logic reduced_current_select;
		logic force_port_detection;
		logic [2:0] input_voltage_floor;
		logic timer_stretch_enable;
		logic [1:0] safety_limit_select;
		logic battery_isolate_enable;
		logic thermistor_monitor_enable;
		logic [1:0] port_detect_result;
		logic [7:0] rdata;
		logic [15:0] vbat_mv;
		logic [15:0] chg_ma;
		logic ext_prog;
		logic [15:0] term_ma;
		logic [15:0] floor_mv;
		logic det_start;
		logic half_speed;
		logic [9:0] limit_min;
		logic timer_off;
		logic therm_active;
		logic suspend;
		logic fet_off;
		logic [1:0] owner;
	} regs_s;

	regs_s st_q;
	regs_s st_d;
	logic [1:0] owner_w;

	// Weighted field decoders
	function automatic logic [15:0] scale(input logic [15:0] base, input logic [15:0] step,
		input logic [5:0] code);
		scale = 16'(base + 16'(step * {10'h000, code}));
	endfunction : scale

	function automatic logic [2:0] therm_code(input logic en, input logic open,
		input logic freeze, input logic cold);
		if (!en || open) begin
			therm_code = charger_regs_pkg::THERM_OPEN;
		end else if (freeze) begin
			therm_code = charger_regs_pkg::THERM_FREEZE;
		end else if (cold) begin
			therm_code = THREE_ZONE ? charger_regs_pkg::THERM_ZONE
				: charger_regs_pkg::THERM_COLD;
		end else begin
			therm_code = charger_regs_pkg::THERM_NORMAL;
		end
	endfunction : therm_code

	loop_arbiter u_arb (
		.clk_sys_i(clk_sys_i),
		.rst_i(rst_i),
		.floor_req_i(st_q.sync2[0]),
		.inlim_req_i(st_q.sync2[1]),
		.thermal_req_i(st_q.sync2[2]),
		.owner_o(owner_w)
	);

	// Register writes, latching status, decoding and readback
	always_comb begin
		logic s_floor;
		logic s_inlim;
		logic s_thermal;
		logic s_sys;
		logic s_inhibit;
		logic s_present;
		logic s_cold;
		logic s_freeze;
		logic s_open;
		logic [1:0] s_pins;
		logic [2:0] tcode;
		logic [15:0] reg_ma;
		tcode = charger_regs_pkg::THERM_NORMAL;
		reg_ma = 16'h0000;
		{s_pins, s_open, s_freeze, s_cold, s_present, s_inhibit, s_sys, s_thermal, s_inlim,
			s_floor} = st_q.sync2;
		st_d = st_q;
		// Pins pass two flops; only the second stage is read anywhere
		st_d.sync1 = {config_pins_i, sensor_open_i, temp_freeze_i, temp_cold_i,
			input_present_i, charge_inhibit_pin_i, system_power_loop_i, thermal_loop_i,
			inlim_loop_i, floor_loop_i};
		st_d.sync2 = st_q.sync1;
		if (!DETECT_VARIANT) begin
			st_d.port_detect_result = s_pins;
		end else if (detect_done_i) begin
			st_d.port_detect_result = detect_result_i;
		end
		// Read of loop status clears it; a new engagement in that cycle wins
		if (rd_en_i && addr_i == charger_regs_pkg::ADDR_LOOP) begin
			st_d.loop_code = charger_regs_pkg::LOOP_NONE;
		end
		if (st_q.loop_code == charger_regs_pkg::LOOP_NONE
			|| (rd_en_i && addr_i == charger_regs_pkg::ADDR_LOOP)) begin
			if (owner_w != 2'b00) begin
				st_d.loop_code = owner_w;
			end
		end
		st_d.det_start = 1'b0;
		if (detect_done_i) begin
			st_d.force_port_detection = 1'b0;
		end
		// Writes touch only writable fields
		if (wr_en_i) begin
			unique case (addr_i)
				charger_regs_pkg::ADDR_CURRENT: begin
					st_d.charge_current_code = wdata_i[charger_regs_pkg::CHG_LSB +: 5];
					st_d.termination_threshold = wdata_i[charger_regs_pkg::TERM_LSB +: 3];
				end
				charger_regs_pkg::ADDR_LOOP: begin
					st_d.reduced_current_select = wdata_i[charger_regs_pkg::REDUCED_BIT];
					st_d.input_voltage_floor = wdata_i[charger_regs_pkg::FLOOR_LSB +: 3];
					if (wdata_i[charger_regs_pkg::FORCE_DET_BIT]
						&& !st_q.force_port_detection) begin
						st_d.force_port_detection = 1'b1;
						st_d.det_start = 1'b1;
					end
				end
				charger_regs_pkg::ADDR_TIMER: begin
					st_d.timer_stretch_enable = wdata_i[charger_regs_pkg::STRETCH_BIT];
					st_d.safety_limit_select = wdata_i[charger_regs_pkg::LIMIT_LSB +: 2];
					st_d.battery_isolate_enable = wdata_i[charger_regs_pkg::ISOLATE_BIT];
					st_d.thermistor_monitor_enable = wdata_i[charger_regs_pkg::THERM_EN_BIT];
				end
				default: begin
				end
			endcase
		end
		tcode = therm_code(st_q.thermistor_monitor_enable, s_open, s_freeze, s_cold);
		// Read data, unmapped offsets read zero
		st_d.rdata = st_q.rdata;
		if (rd_en_i) begin
			unique case (addr_i)
				charger_regs_pkg::ADDR_CURRENT: st_d.rdata = {st_q.charge_current_code,
					st_q.termination_threshold};
				charger_regs_pkg::ADDR_LOOP: st_d.rdata = {st_q.loop_code,
					st_q.reduced_current_select, st_q.force_port_detection,
					s_inhibit, st_q.input_voltage_floor};
				charger_regs_pkg::ADDR_TIMER: st_d.rdata = {st_q.timer_stretch_enable,
					st_q.safety_limit_select, st_q.battery_isolate_enable,
					st_q.thermistor_monitor_enable, tcode};
				default: st_d.rdata = 8'h00;
			endcase
		end
		st_d.vbat_mv = scale(charger_regs_pkg::VBAT_BASE_MV, charger_regs_pkg::VBAT_STEP_MV,
			battery_regulation_voltage_i);
		st_d.ext_prog = (st_q.charge_current_code == charger_regs_pkg::CHG_EXTERNAL);
		reg_ma = scale(charger_regs_pkg::CHG_BASE_MA, charger_regs_pkg::CHG_STEP_MA,
			{1'b0, st_q.charge_current_code});
		if (st_q.reduced_current_select) begin
			st_d.chg_ma = charger_regs_pkg::REDUCED_MA;
		end else if (THREE_ZONE && tcode == charger_regs_pkg::THERM_ZONE) begin
			st_d.chg_ma = charger_regs_pkg::RESTRICT_MA;
		end else begin
			st_d.chg_ma = reg_ma;
		end
		if (THREE_ZONE && tcode == charger_regs_pkg::THERM_ZONE) begin
			st_d.vbat_mv = charger_regs_pkg::RESTRICT_MV;
		end
		// External mode reports zero termination current; the one-tenth level is not decoded here
		if (st_d.ext_prog) begin
			st_d.term_ma = 16'h0000;
		end else begin
			st_d.term_ma = scale(charger_regs_pkg::TERM_BASE_MA, charger_regs_pkg::TERM_STEP_MA,
				{3'b000, st_q.termination_threshold});
		end
		st_d.floor_mv = scale(charger_regs_pkg::FLOOR_BASE_MV, charger_regs_pkg::FLOOR_STEP_MV,
			{3'b000, st_q.input_voltage_floor});
		st_d.half_speed = st_q.timer_stretch_enable
			&& (s_thermal || s_floor || s_sys);
		unique case (st_q.safety_limit_select)
			charger_regs_pkg::LIMIT_SHORT: st_d.limit_min = charger_regs_pkg::MIN_SHORT;
			charger_regs_pkg::LIMIT_SIX: st_d.limit_min = charger_regs_pkg::MIN_SIX;
			charger_regs_pkg::LIMIT_NINE: st_d.limit_min = charger_regs_pkg::MIN_NINE;
			charger_regs_pkg::LIMIT_OFF: st_d.limit_min = 10'h000;
		endcase
		st_d.timer_off = (st_q.safety_limit_select == charger_regs_pkg::LIMIT_OFF);
		st_d.therm_active = st_q.thermistor_monitor_enable;
		st_d.suspend = st_q.thermistor_monitor_enable && (tcode == charger_regs_pkg::THERM_COLD
			|| tcode == charger_regs_pkg::THERM_FREEZE);
		st_d.fet_off = st_q.battery_isolate_enable && !s_present;
		st_d.owner = owner_w;
	end

	// Register stage, reset values from the package
	always_ff @(posedge clk_sys_i or posedge rst_i) begin
		if (rst_i) begin
			st_q <= '0;
			st_q.charge_current_code <= charger_regs_pkg::RST_CURRENT[7:3];
			st_q.termination_threshold <= charger_regs_pkg::RST_CURRENT[2:0];
			st_q.input_voltage_floor <= charger_regs_pkg::RST_LOOP[2:0];
			st_q.timer_stretch_enable <= charger_regs_pkg::RST_TIMER[7];
			st_q.safety_limit_select <= charger_regs_pkg::RST_TIMER[6:5];
			st_q.battery_isolate_enable <= charger_regs_pkg::RST_TIMER[4];
			st_q.thermistor_monitor_enable <= charger_regs_pkg::RST_TIMER[3];
			st_q.ext_prog <= 1'b1;
			st_q.vbat_mv <= charger_regs_pkg::VBAT_BASE_MV;
			st_q.chg_ma <= charger_regs_pkg::CHG_BASE_MA;
			st_q.floor_mv <= charger_regs_pkg::FLOOR_BASE_MV;
			st_q.limit_min <= charger_regs_pkg::MIN_SIX;
			st_q.therm_active <= 1'b1;
		end else begin
			st_q <= st_d;
		end
	end

	assign rdata_o = st_q.rdata;
	assign battery_voltage_mv_o = st_q.vbat_mv;
	assign charge_current_ma_o = st_q.chg_ma;
	assign external_current_program_o = st_q.ext_prog;
	assign termination_ma_o = st_q.term_ma;
	assign input_floor_mv_o = st_q.floor_mv;
	assign detect_start_o = st_q.det_start;
	assign timer_half_speed_o = st_q.half_speed;
	assign safety_limit_min_o = st_q.limit_min;
	assign safety_timer_off_o = st_q.timer_off;
	assign thermistor_active_o = st_q.therm_active;
	assign charge_suspend_o = st_q.suspend;
	assign battery_fet_off_o = st_q.fet_off;
	assign loop_owner_o = st_q.owner;

	a_loop_latch_hold: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		(st_q.loop_code != 2'b00 && !(rd_en_i && addr_i == charger_regs_pkg::ADDR_LOOP))
		|=> $stable(st_q.loop_code))
		else $error("Loop status changed without a read");
	a_loop_first_only: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		(st_q.loop_code == 2'b00 && owner_w != 2'b00) |=> (st_q.loop_code == $past(owner_w)))
		else $error("Loop status missed the engaged loop");
	a_force_det_clear: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		(detect_done_i && !wr_en_i) |=> !st_q.force_port_detection)
		else $error("Force detection bit not cleared");
	a_det_pulse: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		detect_start_o |=> !detect_start_o)
		else $error("Detection start longer than one cycle");
	a_reduced_current: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		st_q.reduced_current_select |=> (charge_current_ma_o == charger_regs_pkg::REDUCED_MA))
		else $error("Reduced current not applied");
	a_ext_mode: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		(st_q.charge_current_code == 5'h1f) |=> external_current_program_o)
		else $error("External current mode not selected");
	a_timer_off: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		(st_q.safety_limit_select == 2'b11) |=> safety_timer_off_o && safety_limit_min_o == 10'h000)
		else $error("Safety timers not disabled");
	a_stretch_off: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		!st_q.timer_stretch_enable |=> !timer_half_speed_o)
		else $error("Timer slowed while stretch disabled");
	a_isolate_fet: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		(st_q.battery_isolate_enable && !st_q.sync2[5]) |=> battery_fet_off_o)
		else $error("Battery FET not switched off");
	a_floor_scale: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		(st_q.input_voltage_floor == 3'b010) |=> (input_floor_mv_o == 16'h1108))
		else $error("Input floor decode wrong");
	a_port_pins: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		!DETECT_VARIANT |=> (st_q.port_detect_result == $past(st_q.sync2[SYNC_W-1 -: 2])))
		else $error("Port field does not follow the config pins");
	a_port_detect: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		(DETECT_VARIANT && detect_done_i)
		|=> (st_q.port_detect_result == $past(detect_result_i)))
		else $error("Port field missed the detection result");
	a_inhibit_read: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		(rd_en_i && addr_i == charger_regs_pkg::ADDR_LOOP)
		|=> (rdata_o[charger_regs_pkg::INHIBIT_BIT] == $past(st_q.sync2[4])))
		else $error("Inhibit bit does not show the pin level");
	a_therm_suspend: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		(st_q.thermistor_monitor_enable && !st_q.sync2[8] && st_q.sync2[7])
		|=> charge_suspend_o)
		else $error("Charging not suspended below freeze");
	a_zone_restrict: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		(THREE_ZONE && st_q.thermistor_monitor_enable && !st_q.sync2[8] && !st_q.sync2[7]
		&& st_q.sync2[6]) |=> (battery_voltage_mv_o == charger_regs_pkg::RESTRICT_MV
		&& !charge_suspend_o))
		else $error("Cool zone restriction not applied");
	a_stretch_on: assert property (@(posedge clk_sys_i) disable iff (rst_i)
		(st_q.timer_stretch_enable && (st_q.sync2[0] || st_q.sync2[2] || st_q.sync2[3]))
		|=> timer_half_speed_o)
		else $error("Timer not slowed while a slowing loop runs");
endmodule : charger_config_registers

// File: host_model.sv
// Host model that issues single-byte register reads and writes on the strobe port
`timescale 1ns/1ps
module host_model (
	input wire logic clk_sys_i,
	input wire logic [7:0] rdata_i,
	output logic wr_en_o,
	output logic rd_en_o,
	output logic [7:0] addr_o,
	output logic [7:0] wdata_o
);
	// Idle port at time zero
	initial begin
		wr_en_o = 1'b0;
		rd_en_o = 1'b0;
		addr_o = 8'h00;
		wdata_o = 8'h00;
	end

	// One write; released lines flip so a stale byte never looks live
	task automatic write(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk_sys_i);
		addr_o = a;
		wdata_o = d;
		wr_en_o = 1'b1;
		@(negedge clk_sys_i);
		wr_en_o = 1'b0;
		addr_o = ~a;
		wdata_o = ~d;
	endtask : write

	// One read; data is registered at the taking edge
	task automatic read(input logic [7:0] a, output logic [7:0] d);
		@(negedge clk_sys_i);
		addr_o = a;
		rd_en_o = 1'b1;
		@(negedge clk_sys_i);
		rd_en_o = 1'b0;
		addr_o = ~a;
		d = rdata_i;
	endtask : read
endmodule : host_model

// File: test_charger_config_registers.sv
// Self-checking testbench of the charger register bank
`timescale 1ns/1ps
module test_charger_config_registers;
	logic clk_sys_i = 1'b0;
	logic rst_i = 1'b1;
	logic wr_en_i, rd_en_i;
	logic [7:0] addr_i, wdata_i, rdata_o;
	logic [5:0] battery_regulation_voltage_i = 6'h23;
	logic [1:0] config_pins_i = 2'h0;
	logic charge_inhibit_pin_i = 1'b0;
	logic input_present_i = 1'b1;
	logic floor_loop_i = 1'b0;
	logic inlim_loop_i = 1'b0;
	logic thermal_loop_i = 1'b0;
	logic system_power_loop_i = 1'b0;
	logic temp_cold_i = 1'b0;
	logic temp_freeze_i = 1'b0;
	logic sensor_open_i = 1'b0;
	logic detect_done_i = 1'b0;
	logic [1:0] detect_result_i = 2'h0;
	logic [15:0] battery_voltage_mv_o, charge_current_ma_o, termination_ma_o, input_floor_mv_o;
	logic external_current_program_o, detect_start_o, timer_half_speed_o, safety_timer_off_o;
	logic thermistor_active_o, charge_suspend_o, battery_fet_off_o;
	logic [9:0] safety_limit_min_o;
	logic [1:0] loop_owner_o;
	// Outputs of the three-zone variant whose port field follows the config pins
	logic [15:0] z_vbat, z_chg;
	logic [7:0] z_rdata;
	logic z_susp;
	int miscompares = 0;
	int checked = 0;
	int seed;
	logic [31:0] rnd;
	logic [7:0] c, f, d;
	logic [2:0] tc [5] = '{3'h0, 3'h4, 3'h6, 3'h7, 3'h7};
	logic [9:0] lim [4] = '{10'h02d, 10'h168, 10'h21c, 10'h000};

	// 40 MHz clock
	always #12.5 clk_sys_i = ~clk_sys_i;

	charger_config_registers charger_config_registers_i (.*);
	// Second variant shares every input; only the outputs it is judged on are kept
	charger_config_registers #(.THREE_ZONE(1'b1), .DETECT_VARIANT(1'b0))
		charger_config_registers_zone_i (.*, .rdata_o(z_rdata), .battery_voltage_mv_o(z_vbat),
		.charge_current_ma_o(z_chg), .external_current_program_o(), .termination_ma_o(),
		.input_floor_mv_o(), .detect_start_o(), .timer_half_speed_o(), .safety_limit_min_o(),
		.safety_timer_off_o(), .thermistor_active_o(), .charge_suspend_o(z_susp),
		.battery_fet_off_o(), .loop_owner_o());
	host_model host_model_i (.clk_sys_i(clk_sys_i), .rdata_i(rdata_o), .wr_en_o(wr_en_i),
		.rd_en_o(rd_en_i), .addr_o(addr_i), .wdata_o(wdata_i));

	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			miscompares++;
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check

	// Register read compared as a byte
	task automatic check_reg(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] v;
		host_model_i.read(a, v);
		check({8'h00, v}, {8'h00, exp});
	endtask : check_reg

	task automatic cycles(input int n);
		repeat (n) @(negedge clk_sys_i);
	endtask : cycles

	// Expected charge current: reduced mode overrides the code
	function automatic logic [15:0] chg_exp(input logic [7:0] r, input logic red);
		return red ? 16'h014a : 16'h01f4 + 16'h0032 * {11'h000, r[7:3]};
	endfunction : chg_exp

	task automatic results;
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : results

	// Hang guard
	initial begin
		repeat (50000) @(posedge clk_sys_i);
		miscompares++;
		results();
	end

	initial begin
		seed = 32'h9ce3;
		cycles(20);
		rst_i = 1'b0;
		cycles(4);
		check_reg(8'h03, 8'hf8);
		check_reg(8'h04, 8'h02);
		check_reg(8'h05, 8'ha8);
		check_reg(8'h07, 8'h00);
		check(battery_voltage_mv_o, 16'h1068);
		check(16'(external_current_program_o), 16'h0001);
		check(input_floor_mv_o, 16'h1108);
		check(16'(safety_limit_min_o), 16'h0168);
		check(16'(thermistor_active_o), 16'h0001);
		$display("test reset done");
		// Random settings with corner codes first: zero, external, top register code
		for (int i = 0; i < 12; i++) begin
			rnd = $random(seed);
			c = (i == 0) ? 8'h07 : (i == 1) ? 8'hff : (i == 2) ? 8'hf7 : rnd[7:0];
			f = rnd[15:8];
			battery_regulation_voltage_i = rnd[21:16];
			charge_inhibit_pin_i = rnd[22];
			config_pins_i = rnd[24:23];
			host_model_i.write(8'h03, c);
			host_model_i.write(8'h04, {2'h0, f[5], 2'h0, f[2:0]});
			cycles(4);
			check(battery_voltage_mv_o, 16'h0dac + 16'h0014 * {10'h000, rnd[21:16]});
			check(charge_current_ma_o, chg_exp(c, f[5]));
			check(16'(external_current_program_o), 16'(c[7:3] == 5'h1f));
			check(termination_ma_o, (c[7:3] == 5'h1f) ? 16'h0000
				: 16'h0032 + 16'h0019 * {13'h0000, c[2:0]});
			check(input_floor_mv_o, 16'h1068 + 16'h0050 * {13'h0000, f[2:0]});
			check_reg(8'h03, c);
			check_reg(8'h04, {2'h0, f[5], 1'b0, rnd[22], f[2:0]});
		end
		$display("test settings done");
		// Every limit code; read-only code bits written as ones stay clear
		for (int i = 0; i < 4; i++) begin
			host_model_i.write(8'h05, {1'b1, i[1:0], 5'h0f});
			cycles(3);
			check(16'(safety_limit_min_o), 16'(lim[i]));
			check(16'(safety_timer_off_o), 16'(i == 3));
			check_reg(8'h05, {1'b1, i[1:0], 5'h08});
		end
		// Stretch against each slowing loop
		for (int i = 0; i < 8; i++) begin
			host_model_i.write(8'h05, {i[0], 7'h08});
			thermal_loop_i = (i[2:1] == 2'h1);
			floor_loop_i = (i[2:1] == 2'h2);
			system_power_loop_i = (i[2:1] == 2'h3);
			cycles(6);
			check(16'(timer_half_speed_o), 16'(i[0] && i[2:1] != 2'h0));
		end
		$display("test timer done");
		// Thermistor cases: normal, cold, freeze, open, disabled
		for (int i = 0; i < 5; i++) begin
			host_model_i.write(8'h05, {4'ha, i != 4, 3'h0});
			temp_cold_i = (i == 1 || i == 2);
			temp_freeze_i = (i == 2);
			sensor_open_i = (i == 3);
			cycles(6);
			check_reg(8'h05, {4'ha, i != 4, tc[i]});
			check({8'h00, z_rdata}, {8'h00, 4'ha, i != 4, ((i == 1) ? 3'h5 : tc[i])});
			check(16'(thermistor_active_o), 16'(i != 4));
			if (i < 3) begin
				check(16'(charge_suspend_o), 16'(i != 0));
				check(16'(z_susp), 16'(i == 2));
			end
			if (i == 1) begin
				check(z_vbat, 16'h0f3c);
				check(z_chg, f[5] ? 16'h014a : 16'h0064);
			end
		end
		sensor_open_i = 1'b0;
		host_model_i.write(8'h05, 8'hb8);
		input_present_i = 1'b0;
		cycles(6);
		check(16'(battery_fet_off_o), 16'h0001);
		input_present_i = 1'b1;
		cycles(6);
		check(16'(battery_fet_off_o), 16'h0000);
		$display("test thermistor done");
		// Each loop alone: owner, latched status, clear on read
		system_power_loop_i = 1'b0;
		charge_inhibit_pin_i = 1'b0;
		host_model_i.write(8'h04, 8'h02);
		cycles(6);
		host_model_i.read(8'h04, d);
		host_model_i.read(8'h04, d);
		for (int i = 1; i < 4; i++) begin
			floor_loop_i = (i == 1);
			inlim_loop_i = (i == 2);
			thermal_loop_i = (i == 3);
			cycles(8);
			check(16'(loop_owner_o), 16'(i));
			{floor_loop_i, inlim_loop_i, thermal_loop_i} = 3'h0;
			cycles(8);
			check_reg(8'h04, {i[1:0], 6'h02});
			check_reg(8'h04, 8'h02);
		end
		// Later thermal loop must not displace the first one
		inlim_loop_i = 1'b1;
		cycles(8);
		thermal_loop_i = 1'b1;
		cycles(8);
		check(16'(loop_owner_o), 16'h0002);
		check_reg(8'h04, 8'h82);
		{inlim_loop_i, thermal_loop_i} = 2'h0;
		cycles(8);
		check_reg(8'h04, 8'h82);
		check_reg(8'h04, 8'h02);
		$display("test loop done");
		// Forced detection: one start pulse, bit clears on completion
		host_model_i.write(8'h04, 8'h12);
		check(16'(detect_start_o), 16'h0001);
		cycles(1);
		check(16'(detect_start_o), 16'h0000);
		check_reg(8'h04, 8'h12);
		detect_result_i = 2'h2;
		detect_done_i = 1'b1;
		cycles(1);
		detect_done_i = 1'b0;
		cycles(2);
		check_reg(8'h04, 8'h02);
		$display("test detect done");
		results();
	end
endmodule : test_charger_config_registers
